//--- sic_defines.svh
/*
  Register indices, bit positions, reset values and prescaler
  masks of the serial interface block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SIC_DEFINES_SVH
`define SIC_DEFINES_SVH

// Register indices; byte address is four times the index
`define SIC_IDX_MODE 18'h0ff48
`define SIC_IDX_CTRL 18'h0ff49
`define SIC_IDX_DATA 18'h0ff4a
`define SIC_IDX_PRIO 18'h0ff20
`define SIC_IDX_IEN  18'h0ff23
`define SIC_IDX_IFLG 18'h0ff25

// Control and status bit positions
`define SIC_TRANSMIT_ENABLE  0
`define SIC_TRANSMIT_TRIGGER 1
`define SIC_RECEIVE_ENABLE  2
`define SIC_RECEIVE_TRIGGER 3
`define SIC_OER   4
`define SIC_PER   5
`define SIC_FER   6

// Interrupt bit positions and priority field
`define SIC_IRQ_TX  0
`define SIC_IRQ_RX  1
`define SIC_IRQ_ERR 2
`define SIC_PRIO_LSB 4

// Reset values
`define SIC_RST_MODE 8'h00
`define SIC_RST_BYTE 8'h00

// Prescaler masks for the three oscillator divides
`define SIC_DIV4_M  4'h3
`define SIC_DIV8_M  4'h7
`define SIC_DIV16_M 4'hf

`endif

//--- sic_peer_model.sv
/*
  Remote serial peer: asynchronous send and receive, capture of a
  synchronous master and clocking of a synchronous slave.
  Assumes resolved pin levels from the bench, pull-ups on all pins.
*/
module sic_peer_model
  import sic_pkg::*;
(
  // Clock
  input  wire logic      hclk,
  // Pins
  input  wire sic_pins_t pin,
  output sic_pins_t      drv,
  output sic_pins_t      oe
);
  timeunit 1ns;
  timeprecision 1ns;

  // Line idles high; sclk is only driven within a frame
  initial
  begin
    drv = 4'hf;
    oe  = 4'h1;
  end

  // Start low, bits LSB first, caller picks the stop level
  task automatic asend(input logic [8:0] b, input int p);
    drv.serial_input_pin <= 1'b0;
    repeat (p) @(posedge hclk);
    for (int i = 0; i < 9; i++)
    begin
      drv.serial_input_pin <= b[i];
      repeat (p) @(posedge hclk);
    end
    drv.serial_input_pin <= 1'b1;
  endtask

  // Mid-bit sampling after the falling start edge
  task automatic arecv(output logic [9:0] b, input int n, input int p);
    b = 10'h000;
    for (int i = 0; i < 5000 && pin.serial_output_pin !== 1'b0; i++)
      @(posedge hclk);
    repeat (p / 2) @(posedge hclk);
    for (int i = 0; i < n; i++)
    begin
      repeat (p) @(posedge hclk);
      b[i] = pin.serial_output_pin;
    end
  endtask

  // Data taken at each rising serial clock
  task automatic scap(output logic [7:0] d);
    d = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      for (int k = 0; k < 900 && pin.sclk !== 1'b0; k++)
        @(posedge hclk);
      for (int k = 0; k < 900 && pin.sclk !== 1'b1; k++)
        @(posedge hclk);
      d[i] = pin.serial_output_pin;
    end
  endtask

  // Eight clocks, data set while low so the rise sees it stable
  task automatic sdrive(input logic [7:0] d, input int p);
    oe.sclk <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      drv.serial_input_pin  <= d[i];
      drv.sclk <= 1'b0;
      repeat (p) @(posedge hclk);
      drv.sclk <= 1'b1;
      repeat (p) @(posedge hclk);
    end
    oe.sclk <= 1'b0;
    drv.serial_input_pin <= 1'b1;
  endtask
endmodule // sic_peer_model

//--- sic_pkg.sv
/*
  Types of the serial interface block: modes, clock sources,
  state codes, the mode register layout and the pin group.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sic_pkg;

  typedef enum logic [1:0] {
    SIC_SYNC_MASTER = 2'b00,
    SIC_SYNC_SLAVE  = 2'b01,
    SIC_ASYNC7      = 2'b10,
    SIC_ASYNC8      = 2'b11
  } sic_mode_t;

  typedef enum logic [1:0] {
    SIC_CLK_DIV16 = 2'b00,
    SIC_CLK_DIV8  = 2'b01,
    SIC_CLK_DIV4  = 2'b10,
    SIC_CLK_TIMER = 2'b11
  } sic_clksrc_t;

  typedef enum logic {
    SIC_TX_IDLE  = 1'b0,
    SIC_TX_SHIFT = 1'b1
  } sic_tx_st_t;

  typedef enum logic [1:0] {
    SIC_RX_IDLE  = 2'b00,
    SIC_RX_HUNT  = 2'b01,
    SIC_RX_SHIFT = 2'b10
  } sic_rx_st_t;

  // Mode register, bit 7 down to bit 0
  typedef struct packed {
    logic        unused;
    logic        parity_enable;
    logic        parity_type;
    sic_clksrc_t clock_source;
    sic_mode_t   transfer_mode;
    logic        interface_pin_enable;
  } sic_mode_cfg_t;

  // Shared port pins, bit 0 is serial input
  typedef struct packed {
    logic slave_ready_pin;
    logic sclk;
    logic serial_output_pin;
    logic serial_input_pin;
  } sic_pins_t;

endpackage

//--- sic_serial_ctrl.sv
/*
  Serial interface: AHB-Lite register slave, prescaler, transmit
  and receive shifters for clock-synchronous and asynchronous
  modes, error flags and serial interrupt request.
  Assumes pins synchronous to hclk and a single AHB-Lite master.
*/
// Implementation choice: register access over AHB-Lite.
`include "sic_defines.svh"

// Notes on behaviour
// - Pin enable routes both data pins; sclk in sync modes, ready in slave
// - Mode field picks sync master/slave, async 7/8
// - Clock source: timer, fosc/4, /8, /16
// - Sync slave clocks from external serial clock
// - Parity enable adds and checks parity
// - No parity in clock-synchronous modes
// - Parity type: 1 odd, 0 even
// - Transmit enable bit gates transmitter
// - Transmit trigger starts send, reads busy
// - Receive enable bit gates receiver
// - Sync receive trigger starts one character
// - Slave ready goes low on receive trigger
// - Async receive trigger empties buffer, else overrun
// - Receive trigger reads back receive busy
// - Ones high, zeros low; 7-bit drops bit 7
// - Receive buffer apart from shifter, async only; rx_buf_q also loads in sync modes
// - Three factor flags, write one clears
// - Three readable interrupt enable bits
// - Two-bit serial interrupt priority level
// - Error flags clear on reset, receive off, W1C
// - Zero stop bit sets framing error, keeps data
module sic_serial_ctrl
  import sic_pkg::*;
#(
  parameter int unsigned DIV_W = 4
)
(
  // Clock, reset, freeze
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Timer underflow clock source
  input  wire logic        timer_uflow,
  // Shared port pins
  input  wire sic_pins_t   port_in,
  input  wire sic_pins_t   gpio_out,
  input  wire sic_pins_t   gpio_oe,
  output sic_pins_t        port_out,
  output sic_pins_t        port_oe,
  // Serial interrupt request
  output logic             irq_req,
  output logic      [1:0]  irq_level
);

  // Prescaler must hold the divide-by-16 count
  if (DIV_W < 4) begin : g_chk
    $error("DIV_W must be at least 4");
  end

  // Register state
  sic_mode_cfg_t mode_q;
  logic        transmit_enable_q, receive_enable_q;
  logic        per_q, oer_q, fer_q;
  logic [1:0]  prio_q;
  logic [2:0]  ien_q, iflg_q;
  logic [7:0]  tx_data_q, rx_buf_q;
  logic        rx_full_q;
  // Bus state
  logic        dp_wr_q;
  logic [17:0] dp_idx_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q, hresp_q;
  // Engine state
  logic [DIV_W-1:0] div_q;
  sic_tx_st_t  tx_st_q;
  sic_rx_st_t  rx_st_q;
  logic [11:0] tx_sh_q;
  logic [3:0]  tx_cnt_q, tx_len_q, rx_cnt_q;
  logic [9:0]  rx_sh_q;
  logic        sclk_q, sclk_prev_q, slave_ready_pin_q;
  sic_pins_t   pin_out_q, pin_oe_q;
  logic        irq_req_q;
  logic [1:0]  irq_level_q;

  // Builds an async frame, start at bit 0, ones above
  function automatic logic [10:0] build_frame(
    input logic [7:0] d,
    input logic       seven,
    input logic       par_on,
    input logic       odd
  );
    logic [10:0] f;
    logic        p;
    f = 11'h7ff;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (i < 7 || !seven)
        f[i+1] = d[i];
    end
    p = (seven ? ^d[6:0] : ^d) ^ odd;
    if (par_on)
      f[seven ? 8 : 9] = p;
    return f;
  endfunction

  // Address phase decode
  logic [17:0] ap_idx;
  logic        ap_ok;
  logic [7:0]  rd_byte, ctrl_rd;
  assign ap_idx = haddr[19:2];
  assign ap_ok  = hsel & htrans[1] & hready
                & (haddr[31:20] == 12'h000) & (haddr[1:0] == 2'b00);

  // Read mux; unmapped and foreign bits read zero
  assign ctrl_rd = {1'b0, fer_q, per_q, oer_q,
                    rx_st_q == SIC_RX_SHIFT, receive_enable_q,
                    tx_st_q == SIC_TX_SHIFT, transmit_enable_q};
  assign rd_byte =
    (ap_idx == `SIC_IDX_MODE) ? mode_q :
    (ap_idx == `SIC_IDX_CTRL) ? ctrl_rd :
    (ap_idx == `SIC_IDX_DATA) ? rx_buf_q :
    (ap_idx == `SIC_IDX_PRIO) ? {2'b00, prio_q, 4'h0} :
    (ap_idx == `SIC_IDX_IEN)  ? {5'h00, ien_q} :
    (ap_idx == `SIC_IDX_IFLG) ? {5'h00, iflg_q} : 8'h00;

  // Zero-wait slave; read data captured in address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_q     <= 1'b0;
      dp_idx_q    <= 18'h00000;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
    else
    begin
      dp_wr_q  <= ap_ok & hwrite;
      dp_idx_q <= ap_idx;
      if (ap_ok && !hwrite)
        hrdata_q <= {24'h000000, rd_byte};
    end
  end

  // Data phase write strobes
  logic [7:0] wb;
  logic       w_mode, w_ctrl, w_data, w_prio, w_ien, w_iflg;
  assign wb     = hwdata[7:0];
  assign w_mode = ce & dp_wr_q & (dp_idx_q == `SIC_IDX_MODE);
  assign w_ctrl = ce & dp_wr_q & (dp_idx_q == `SIC_IDX_CTRL);
  assign w_data = ce & dp_wr_q & (dp_idx_q == `SIC_IDX_DATA);
  assign w_prio = ce & dp_wr_q & (dp_idx_q == `SIC_IDX_PRIO);
  assign w_ien  = ce & dp_wr_q & (dp_idx_q == `SIC_IDX_IEN);
  assign w_iflg = ce & dp_wr_q & (dp_idx_q == `SIC_IDX_IFLG);

  // Mode decode
  logic is_async, is_slave, is_master, seven, par_on;
  assign is_async  = mode_q.transfer_mode[1];
  assign is_slave  = mode_q.transfer_mode == SIC_SYNC_SLAVE;
  assign is_master = mode_q.transfer_mode == SIC_SYNC_MASTER;
  assign seven     = mode_q.transfer_mode == SIC_ASYNC7;
  assign par_on    = mode_q.parity_enable & is_async;

  // Clock source select; slave ignores it
  logic tick;
  assign tick =
    (mode_q.clock_source == SIC_CLK_DIV4) ?
      ((div_q[3:0] & `SIC_DIV4_M) == `SIC_DIV4_M) :
    (mode_q.clock_source == SIC_CLK_DIV8) ?
      ((div_q[3:0] & `SIC_DIV8_M) == `SIC_DIV8_M) :
    (mode_q.clock_source == SIC_CLK_DIV16) ?
      ((div_q[3:0] & `SIC_DIV16_M) == `SIC_DIV16_M) :
    timer_uflow;

  // Serial clock edges: own clock or external pin
  logic sync_fall, sync_rise;
  assign sync_fall = is_slave ? (sclk_prev_q & ~port_in.sclk)
                              : (tick & sclk_q);
  assign sync_rise = is_slave ? (~sclk_prev_q & port_in.sclk)
                              : (tick & ~sclk_q);

  // Triggers; enable written in the same access counts
  logic tx_busy, rx_busy, transmit_trigger_go, receive_trigger_wr, rx_start;
  assign tx_busy  = tx_st_q == SIC_TX_SHIFT;
  assign rx_busy  = rx_st_q == SIC_RX_SHIFT;
  assign transmit_trigger_go = w_ctrl & wb[`SIC_TRANSMIT_TRIGGER] & wb[`SIC_TRANSMIT_ENABLE]
                  & ~tx_busy;
  assign receive_trigger_wr = w_ctrl & wb[`SIC_RECEIVE_TRIGGER] & wb[`SIC_RECEIVE_ENABLE];
  assign rx_start = receive_trigger_wr & ~is_async & ~rx_busy
                  & ~tx_busy;

  // Transmit stepping
  logic tx_adv, tx_inc, tx_last, tx_done, tx_abort;
  assign tx_adv   = is_async ? tick
                             : (sync_fall & (tx_cnt_q != 4'h0));
  assign tx_inc   = is_async ? tick : sync_rise;
  assign tx_last  = tx_busy & tx_inc
                  & (tx_cnt_q == tx_len_q - 4'h1);
  assign tx_done  = ce & tx_last;
  assign tx_abort = ~transmit_enable_q & ~transmit_trigger_go;

  // Receive stepping and frame decode
  logic [3:0] rx_len;
  logic [9:0] rx_w, rx_al;
  logic       rx_ev, rx_last, rx_done, rx_abort;
  logic       perr, ferr, ovr, par_sum;
  logic [7:0] rx_data;
  assign rx_len   = is_async ? ((seven ? 4'd8 : 4'd9)
                  + {3'b000, par_on}) : 4'd8;
  assign rx_ev    = is_async ? tick : sync_rise;
  assign rx_w     = {port_in.serial_input_pin, rx_sh_q[9:1]};
  assign rx_al    = rx_w >> (4'd10 - rx_len);
  assign rx_last  = rx_busy & rx_ev
                  & (rx_cnt_q == rx_len - 4'h1);
  assign rx_done  = ce & rx_last;
  assign rx_abort = ~receive_enable_q & ~receive_trigger_wr;
  assign rx_data  = seven ? {1'b0, rx_al[6:0]} : rx_al[7:0];
  assign par_sum  = seven ? ^rx_al[7:0] : ^rx_al[8:0];
  assign perr     = par_on & (par_sum != mode_q.parity_type);
  assign ferr     = is_async & ~rx_al[rx_len-4'h1];
  assign ovr      = is_async & (rx_full_q | receive_trigger_wr);

  // Interrupt factor set terms
  logic [2:0] iflg_set, iflg_clr;
  assign iflg_set = {rx_done & (perr | ferr | ovr),
                     rx_done & ~ovr,
                     tx_done};
  assign iflg_clr = w_iflg ? wb[2:0] : 3'b000;

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_q    <= `SIC_RST_MODE;
      transmit_enable_q    <= 1'b0;
      receive_enable_q    <= 1'b0;
      prio_q    <= 2'b00;
      ien_q     <= 3'b000;
      tx_data_q <= `SIC_RST_BYTE;
    end
    else if (ce)
    begin
      if (w_mode)
        mode_q <= {1'b0, wb[6:0]};
      if (w_ctrl)
      begin
        transmit_enable_q <= wb[`SIC_TRANSMIT_ENABLE];
        receive_enable_q <= wb[`SIC_RECEIVE_ENABLE];
      end
      if (w_prio)
        prio_q <= wb[`SIC_PRIO_LSB+1:`SIC_PRIO_LSB];
      if (w_ien)
        ien_q <= wb[2:0];
      if (w_data)
        tx_data_q <= wb;
    end
  end

  // Error flags: set wins over clear, receive off clears
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      per_q  <= 1'b0;
      oer_q  <= 1'b0;
      fer_q  <= 1'b0;
      iflg_q <= 3'b000;
    end
    else if (ce)
    begin
      per_q  <= receive_enable_q & ((per_q & ~(w_ctrl & wb[`SIC_PER]))
              | (rx_done & perr));
      oer_q  <= receive_enable_q & ((oer_q & ~(w_ctrl & wb[`SIC_OER]))
              | (rx_done & ovr));
      fer_q  <= receive_enable_q & ((fer_q & ~(w_ctrl & wb[`SIC_FER]))
              | (rx_done & ferr));
      iflg_q <= (iflg_q & ~iflg_clr) | iflg_set;
    end
  end

  // Prescaler runs freely from hclk
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_q <= '0;
    else if (ce)
      div_q <= div_q + 1'b1;
  end

  // Transmit shifter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_st_q  <= SIC_TX_IDLE;
      tx_sh_q  <= 12'hfff;
      tx_cnt_q <= 4'h0;
      tx_len_q <= 4'h8;
    end
    else if (ce)
    begin
      if (tx_abort)
      begin
        tx_st_q <= SIC_TX_IDLE;
        tx_sh_q <= 12'hfff;
      end
      else
      begin
        unique case (tx_st_q)
          SIC_TX_IDLE:
          begin
            if (transmit_trigger_go)
            begin
              tx_st_q  <= SIC_TX_SHIFT;
              tx_cnt_q <= 4'h0;
              if (is_async)
              begin
                // Idle bit below the frame: the first tick comes at any
                // prescaler phase, so the start bit still lasts a full tick
                tx_sh_q  <= {build_frame(tx_data_q, seven, par_on,
                                         mode_q.parity_type), 1'b1};
                tx_len_q <= (seven ? 4'd10 : 4'd11)
                          + {3'b000, par_on};
              end
              else
              begin
                tx_sh_q  <= {4'hf, tx_data_q};
                tx_len_q <= 4'd8;
              end
            end
            else
              tx_sh_q <= 12'hfff; // Line back high one cycle after the end
          end
          SIC_TX_SHIFT:
          begin
            if (tx_adv)
              tx_sh_q <= {1'b1, tx_sh_q[11:1]};
            if (tx_inc)
              tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_last)
              tx_st_q <= SIC_TX_IDLE;
          end
        endcase
      end
    end
  end

  // Receive shifter; async hunts for start while enabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_st_q  <= SIC_RX_IDLE;
      rx_sh_q  <= 10'h000;
      rx_cnt_q <= 4'h0;
    end
    else if (ce)
    begin
      if (rx_abort)
        rx_st_q <= SIC_RX_IDLE;
      else
      begin
        unique case (rx_st_q)
          SIC_RX_IDLE:
          begin
            if (rx_start)
            begin
              rx_st_q  <= SIC_RX_SHIFT;
              rx_cnt_q <= 4'h0;
            end
            else if (is_async && receive_enable_q)
              rx_st_q <= SIC_RX_HUNT;
          end
          SIC_RX_HUNT:
          begin
            if (!is_async)
              rx_st_q <= SIC_RX_IDLE;
            else if (tick && !port_in.serial_input_pin)
            begin
              rx_st_q  <= SIC_RX_SHIFT;
              rx_cnt_q <= 4'h0;
            end
          end
          SIC_RX_SHIFT:
          begin
            if (rx_ev)
            begin
              rx_sh_q  <= rx_w;
              rx_cnt_q <= rx_cnt_q + 4'h1;
            end
            if (rx_last)
              rx_st_q <= is_async ? SIC_RX_HUNT : SIC_RX_IDLE;
          end
          default:
            rx_st_q <= SIC_RX_IDLE;
        endcase
      end
    end
  end

  // Receive buffer; full flag only matters in async
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_buf_q  <= `SIC_RST_BYTE;
      rx_full_q <= 1'b0;
    end
    else if (ce)
    begin
      if (rx_done)
        rx_buf_q <= rx_data;
      rx_full_q <= receive_enable_q & is_async
                 & ((rx_full_q & ~receive_trigger_wr) | rx_done);
    end
  end

  // Master serial clock, idles high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_q      <= 1'b1;
      sclk_prev_q <= 1'b1;
      slave_ready_pin_q      <= 1'b1;
    end
    else if (ce)
    begin
      sclk_prev_q <= port_in.sclk;
      if (is_master && (tx_busy || rx_busy) && tick)
        sclk_q <= ~sclk_q;
      else if (!tx_busy && !rx_busy)
        sclk_q <= 1'b1;
      // Ready low from trigger until the character ends
      if (is_slave && (rx_start || transmit_trigger_go))
        slave_ready_pin_q <= 1'b0;
      else if (tx_done || rx_done || (!tx_busy && !rx_busy))
        slave_ready_pin_q <= 1'b1;
    end
  end

  // Pin routing, registered to keep outputs glitch free
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_out_q <= 4'h0;
      pin_oe_q  <= 4'h0;
    end
    else if (ce)
    begin
      if (mode_q.interface_pin_enable)
      begin
        pin_out_q.serial_input_pin  <= 1'b0;
        pin_oe_q.serial_input_pin   <= 1'b0;
        // Shifter idles high; last sync bit must outlive its rising clock
        pin_out_q.serial_output_pin <= tx_sh_q[0];
        pin_oe_q.serial_output_pin  <= 1'b1;
        pin_out_q.sclk <= is_async ? gpio_out.sclk : sclk_q;
        pin_oe_q.sclk  <= is_async ? gpio_oe.sclk : is_master;
        pin_out_q.slave_ready_pin <= is_slave ? slave_ready_pin_q : gpio_out.slave_ready_pin;
        pin_oe_q.slave_ready_pin  <= is_slave | gpio_oe.slave_ready_pin;
      end
      else
      begin
        pin_out_q <= gpio_out;
        pin_oe_q  <= gpio_oe;
      end
    end
  end

  // Interrupt request toward the CPU's priority logic
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_req_q   <= 1'b0;
      irq_level_q <= 2'b00;
    end
    else if (ce)
    begin
      irq_req_q   <= (|(iflg_q & ien_q)) & (prio_q != 2'b00);
      irq_level_q <= prio_q;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign port_out  = pin_out_q;
  assign port_oe   = pin_oe_q;
  assign irq_req   = irq_req_q;
  assign irq_level = irq_level_q;

  // Checks, clocked on hclk, off during reset
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_PIN_GPIO: assert property (
    ce && !mode_q.interface_pin_enable |=> port_out == $past(gpio_out))
    else $error("pins not returned to port function");
  AST_TX_START: assert property (
    transmit_trigger_go && !tx_busy |=> tx_busy && tx_cnt_q == 4'h0)
    else $error("transmit trigger did not start");
  AST_SYNC_NOPAR: assert property (
    transmit_trigger_go && !is_async |=> tx_sh_q[10:8] == 3'b111 && tx_len_q == 4'd8)
    else $error("parity framed in sync mode");
  AST_SERIAL_OUTPUT_PIN_BIT: assert property (
    ce && mode_q.interface_pin_enable && tx_busy
      |=> port_out.serial_output_pin == $past(tx_sh_q[0]))
    else $error("serial output differs from shifter");
  AST_SLAVE_READY_PIN_LOW: assert property (
    ce && is_slave && rx_start |=> ##1 !port_out.slave_ready_pin)
    else $error("ready not low after receive trigger");
  AST_RX_EMPTY: assert property (
    ce && receive_trigger_wr && is_async && !rx_done |=> !rx_full_q)
    else $error("receive trigger did not empty buffer");
  AST_OVERRUN: assert property (
    rx_done && is_async && rx_full_q && receive_enable_q
      |=> oer_q && iflg_q[`SIC_IRQ_ERR])
    else $error("overrun not flagged");
  AST_FRAMING: assert property (
    rx_done && ferr && receive_enable_q
      |=> fer_q && iflg_q[`SIC_IRQ_ERR] && rx_buf_q == $past(rx_data))
    else $error("framing error not flagged");
  AST_ERR_CLR: assert property (
    ce && !receive_enable_q |=> !per_q && !oer_q && !fer_q)
    else $error("error flags alive with receiver off");
  AST_TX_DONE: assert property (
    tx_done |=> iflg_q[`SIC_IRQ_TX])
    else $error("transmit complete flag lost");
  AST_IRQ_LVL: assert property (
    ce |=> irq_level == $past(prio_q))
    else $error("interrupt level mismatch");

  COV_TX_DONE: cover property (tx_done && is_async);
  COV_RX_DONE: cover property (rx_done && is_async && !ovr);
  COV_SYNC_RX: cover property (rx_done && !is_async);
  COV_OVR:     cover property (rx_done && ovr);

endmodule // sic_serial_ctrl

//--- test_serial_interface_control.sv
/*
  Self-checking bench of the serial interface: AHB-Lite register
  access and transfers against the remote peer model.
  Assumes package, header, design and peer model compiled before.
*/
`include "sic_defines.svh"
module test_serial_interface_control
  import sic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [17:0] MD = `SIC_IDX_MODE;
  localparam logic [17:0] CT = `SIC_IDX_CTRL;
  localparam logic [17:0] DT = `SIC_IDX_DATA;
  localparam logic [17:0] FL = `SIC_IDX_IFLG;

  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic        hreadyout;
  logic        hresp;
  logic        irq_req;
  logic [1:0]  irq_level;
  logic [9:0]  fr;
  logic [7:0]  sd;
  sic_pins_t   pin;
  sic_pins_t   port_out;
  sic_pins_t   port_oe;
  sic_pins_t   peer_drv;
  sic_pins_t   peer_oe;
  int          n_mismatch = 0;
  int          compares = 0;

  // 50 MHz
  always #10 hclk = ~hclk;

  // Design wins a clash; undriven pins float high
  assign pin = (port_oe & port_out) | (~port_oe & peer_oe & peer_drv) | (~port_oe & ~peer_oe);

  sic_serial_ctrl sic_serial_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_uflow(1'b0), .port_in(pin), .gpio_out(4'hc), .gpio_oe(4'hc), .port_out(port_out),
    .port_oe(port_oe), .irq_req(irq_req), .irq_level(irq_level));

  sic_peer_model sic_peer_model_inst (.hclk(hclk), .pin(pin), .drv(peer_drv), .oe(peer_oe));

  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    for (int n = 0; n < 50; n++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        return;
    end
    n_mismatch++;
    give_verdict();
  endtask

  // One single transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [17:0] idx, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {12'h000, idx, 2'h0};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_rdy();
    q = hrdata;
  endtask

  task automatic rd(input string what, input logic [17:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(what, {24'h000000, exp}, q);
  endtask

  // Polling is bounded; a flag that never comes ends the run
  task automatic poll(input logic [7:0] m);
    for (int n = 0; n < 400; n++)
    begin
      bus(1'b0, FL, 8'h00);
      if ((q[7:0] & m) === m)
        return;
    end
    n_mismatch++;
    give_verdict();
  endtask

  task automatic t_reset();
    rd("mode", MD, 8'h00);
    rd("ctrl", CT, 8'h00);
    rd("prio", `SIC_IDX_PRIO, 8'h00);
    rd("ien", `SIC_IDX_IEN, 8'h00);
    rd("iflg", FL, 8'h00);
    chk("gpio", 32'h00cc, {24'h0, port_oe, port_out});
    chk("hresp", 32'h0, {31'h0, hresp});
    bus(1'b1, 18'h0ff4b, 8'hff);
    rd("unmapped", 18'h0ff4b, 8'h00);
  endtask

  task automatic t_regs();
    for (int i = 0; i < 16; i++)
    begin
      bus(1'b1, MD, {3'h0, i[3:0], 1'b0});
      rd("mode", MD, {3'h0, i[3:0], 1'b0});
    end
    bus(1'b1, MD, 8'hff);
    rd("mode_b7", MD, 8'h7f);
    bus(1'b1, `SIC_IDX_IEN, 8'h07);
    rd("ien", `SIC_IDX_IEN, 8'h07);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, `SIC_IDX_PRIO, {2'h0, i[1:0], 4'h0});
      // Level output is one register behind the priority field
      repeat (2) @(posedge hclk);
      chk("level", i, {30'h0, irq_level});
    end
  endtask

  task automatic t_atx();
    bus(1'b1, CT, 8'h00);
    bus(1'b1, MD, 8'h67);
    bus(1'b1, `SIC_IDX_IEN, 8'h01);
    bus(1'b1, `SIC_IDX_PRIO, 8'h20);
    bus(1'b1, DT, 8'ha5);
    chk("pin_oe", 32'h2, {30'h0, port_oe[1:0]});
    fork
      sic_peer_model_inst.arecv(fr, 10, 16);
      begin
        bus(1'b1, CT, 8'h03);
        rd("tx_busy", CT, 8'h03);
      end
    join
    chk("frame", {22'h0, 1'b1, ~^8'ha5, 8'ha5}, {22'h0, fr});
    poll(8'h01);
    chk("irq", 32'h6, {29'h0, irq_req, irq_level});
    rd("tx_idle", CT, 8'h01);
    bus(1'b1, FL, 8'h01);
    rd("iflg_clr", FL, 8'h00);
  endtask

  task automatic t_a7tx();
    bus(1'b1, CT, 8'h00);
    bus(1'b1, MD, 8'h0d);
    bus(1'b1, DT, 8'h7f);
    fork
      sic_peer_model_inst.arecv(fr, 8, 8);
      bus(1'b1, CT, 8'h03);
    join
    chk("frame7", 32'h0ff, {22'h0, fr});
    poll(8'h01);
    bus(1'b1, FL, 8'h01);
  endtask

  task automatic t_arx();
    bus(1'b1, CT, 8'h00);
    bus(1'b1, MD, 8'h07);
    bus(1'b1, CT, 8'h04);
    sic_peer_model_inst.asend({1'b1, 8'h3c}, 16);
    poll(8'h02);
    rd("rx_flags", FL, 8'h02);
    rd("rx_data", DT, 8'h3c);
    bus(1'b1, FL, 8'h02);
    sic_peer_model_inst.asend({1'b1, 8'hc3}, 16);
    poll(8'h04);
    rd("overrun", CT, 8'h14);
    rd("ovr_flags", FL, 8'h04);
    rd("ovr_data", DT, 8'hc3);
    bus(1'b1, FL, 8'h04);
    bus(1'b1, CT, 8'h1c);
    rd("ovr_clr", CT, 8'h04);
    sic_peer_model_inst.asend({1'b0, 8'h55}, 16);
    poll(8'h06);
    rd("framing", CT, 8'h44);
    rd("fer_data", DT, 8'h55);
    bus(1'b1, FL, 8'h06);
    bus(1'b1, CT, 8'h00);
    // Flags clear one cycle after the enable drops
    @(posedge hclk);
    rd("rx_off", CT, 8'h00);
  endtask

  task automatic t_sync();
    bus(1'b1, MD, 8'h51);
    bus(1'b1, DT, 8'h69);
    fork
      sic_peer_model_inst.scap(sd);
      bus(1'b1, CT, 8'h03);
    join
    chk("sync_tx", 32'h69, {24'h0, sd});
    poll(8'h01);
    chk("sclk_idle", 32'h1, {31'h0, pin.sclk});
    bus(1'b1, FL, 8'h01);
    bus(1'b1, CT, 8'h00);
    bus(1'b1, MD, 8'h1b);
    bus(1'b1, CT, 8'h0c);
    rd("rx_busy", CT, 8'h0c);
    chk("slave_ready_pin", 32'h2, {30'h0, port_oe.slave_ready_pin, port_out.slave_ready_pin});
    sic_peer_model_inst.sdrive(8'ha3, 8);
    poll(8'h02);
    rd("slave_rx", DT, 8'ha3);
    rd("rx_stop", CT, 8'h04);
  endtask

  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_regs();
    t_atx();
    t_a7tx();
    t_arx();
    t_sync();
    give_verdict();
  end
endmodule // test_serial_interface_control
